// ===== common/tlv_intc_params.svh
// constants for the two-level interrupt vectoring unit
// assumes an 8-bit register port and a 16-bit program counter
`ifndef TLV_INTC_PARAMS_SVH
`define TLV_INTC_PARAMS_SVH
`define TLV_INTERRUPT_ENABLE_LOW_GROUP_ADDR 8'ha8
`define TLV_IP0_ADDR 8'hb8
`define TLV_INTERRUPT_ENABLE_TIMER2_GROUP_ADDR 8'he8
`define TLV_IP1_ADDR 8'hf8
`define TLV_REG_RESET 8'h00
`define TLV_IP0_MASK 8'h7f
`define TLV_EA_BIT 7
`define TLV_VEC_BASE 16'h0003
`define TLV_VEC_STEP 16'h0008
`define TLV_VEC_LAST 16'h0073
`define TLV_NSRC 15
`endif

// ===== common/tlv_pkg.sv
// types for the two-level interrupt vectoring unit
// assumes nothing beyond the constants header
package tlv_pkg;
    typedef logic [7:0] tlv_byte_t;
    typedef logic [15:0] tlv_addr_t;
    // sources in vector order
    typedef enum logic [3:0] {
        TLV_X0, TLV_T0, TLV_X1SEC, TLV_T1, TLV_UART, TLV_I2C,
        TLV_CT0, TLV_CT1, TLV_CT2, TLV_CT3, TLV_ADC,
        TLV_CM0, TLV_CM1, TLV_CM2, TLV_T2
    } tlv_src_t;
endpackage

// ===== design/tlv_intc.sv
// interrupt polling, priority and vectoring unit with its registers
// assumes request flags come from logic on clk and that the core
// gives a one-cycle sample strobe per machine cycle
//
// The address-and-strobe port is this design's own decision.
`include "tlv_intc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tlv_intc #(
    parameter int NSRC = `TLV_NSRC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire tlv_pkg::tlv_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tlv_pkg::tlv_byte_t reg_rdata,
    // request flags from the sources
    input wire logic ext_request_flag_a,
    input wire logic ext_request_flag_b,
    input wire logic ext0_edge_mode,
    input wire logic ext1_edge_mode,
    input wire logic seconds_flag,
    input wire logic timer0_ovf_flag,
    input wire logic timer1_ovf_flag,
    input wire logic uart_flag,
    input wire logic i2c_flag,
    input wire logic adc_flag,
    input wire logic [3:0] capture_flags,
    input wire logic [2:0] compare_flags,
    input wire logic timer2_ovf_flag,
    // flag clear pulses back to the sources
    output logic clr_timer0_flag,
    output logic clr_timer1_flag,
    output logic clr_ext_flag_a,
    output logic clr_ext_flag_b,
    // instruction sequencer
    input wire logic sample_phase,
    input wire logic last_cycle,
    input wire logic block_instr,
    input wire logic return_from_interrupt_exec,
    output logic call_req,
    output tlv_pkg::tlv_addr_t call_vector,
    output logic push_pc,
    output logic pop_pc,
    output logic level_active_hi,
    output logic level_active_lo
);
    import tlv_pkg::*;

    if (NSRC != `TLV_NSRC) begin : g_bad_nsrc
        $error("tlv_intc serves exactly fifteen sources");
    end

    localparam tlv_src_t POLL_ORDER [15] = '{
        TLV_X0, TLV_I2C, TLV_ADC, TLV_T0, TLV_CT0, TLV_CM0,
        TLV_X1SEC, TLV_CT1, TLV_CM1, TLV_T1, TLV_CT2, TLV_CM2,
        TLV_UART, TLV_CT3, TLV_T2
    };

    tlv_byte_t interrupt_enable_low_group_r;
    tlv_byte_t interrupt_enable_timer2_group_r;
    tlv_byte_t ip0_r;
    tlv_byte_t ip1_r;
    tlv_byte_t rdata_r;
    logic [14:0] flags_now;
    logic [14:0] samp_r;
    logic [14:0] enab;
    logic [14:0] prio;
    logic [14:0] pend;
    logic [14:0] pend_hi;
    logic [14:0] pend_lo;
    logic reg_touch_r;
    logic reg_touch;
    logic blocked;
    logic take_hi;
    logic take_lo;
    logic grant;
    tlv_src_t win_hi;
    tlv_src_t win_lo;
    tlv_src_t win;
    tlv_src_t call_src_r;
    logic call_req_r;
    logic call_hi_r;
    tlv_addr_t call_vector_r;
    logic pop_pc_r;
    logic lvl_hi_r;
    logic lvl_lo_r;
    logic clr_t0_r;
    logic clr_t1_r;
    logic clr_xa_r;
    logic clr_xb_r;

    // register access
    logic sel_interrupt_enable_low_group;
    logic sel_ip0;
    logic sel_interrupt_enable_timer2_group;
    logic sel_ip1;
    assign sel_interrupt_enable_low_group = reg_addr == `TLV_INTERRUPT_ENABLE_LOW_GROUP_ADDR;
    assign sel_ip0 = reg_addr == `TLV_IP0_ADDR;
    assign sel_interrupt_enable_timer2_group = reg_addr == `TLV_INTERRUPT_ENABLE_TIMER2_GROUP_ADDR;
    assign sel_ip1 = reg_addr == `TLV_IP1_ADDR;
    assign reg_touch = (reg_wr || reg_rd) &&
        (sel_interrupt_enable_low_group || sel_ip0 || sel_interrupt_enable_timer2_group || sel_ip1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_low_group_r <= `TLV_REG_RESET;
        end else if (reg_wr && sel_interrupt_enable_low_group) begin
            interrupt_enable_low_group_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_timer2_group_r <= `TLV_REG_RESET;
        end else if (reg_wr && sel_interrupt_enable_timer2_group) begin
            interrupt_enable_timer2_group_r <= reg_wdata;
        end
    end

    // first priority register, top bit reserved
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ip0_r <= `TLV_REG_RESET;
        end else if (reg_wr && sel_ip0) begin
            ip0_r <= reg_wdata & `TLV_IP0_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ip1_r <= `TLV_REG_RESET;
        end else if (reg_wr && sel_ip1) begin
            ip1_r <= reg_wdata;
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= `TLV_REG_RESET;
        end else if (!reg_rd) begin
            rdata_r <= `TLV_REG_RESET;
        end else if (sel_interrupt_enable_low_group) begin
            rdata_r <= interrupt_enable_low_group_r;
        end else if (sel_ip0) begin
            rdata_r <= ip0_r;
        end else if (sel_interrupt_enable_timer2_group) begin
            rdata_r <= interrupt_enable_timer2_group_r;
        end else if (sel_ip1) begin
            rdata_r <= ip1_r;
        end else begin
            rdata_r <= `TLV_REG_RESET;
        end
    end

    // external 1 and seconds share one request
    assign flags_now = {
        timer2_ovf_flag, compare_flags, adc_flag, capture_flags,
        i2c_flag, uart_flag, timer1_ovf_flag,
        ext_request_flag_b | seconds_flag,
        timer0_ovf_flag, ext_request_flag_a
    };

    // per-source enable and level, in vector order
    assign enab = {
        interrupt_enable_timer2_group_r[7:4], interrupt_enable_low_group_r[6], interrupt_enable_timer2_group_r[3:0], interrupt_enable_low_group_r[5:0]
    };
    assign prio = {
        ip1_r[7:4], ip0_r[6], ip1_r[3:0], ip0_r[5:0]
    };

    // capture flags at the sample phase for next poll
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            samp_r <= '0;
        end else if (sample_phase) begin
            samp_r <= flags_now;
        end
    end

    // enable or priority register touched in this machine cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_touch_r <= 1'b0;
        end else if (reg_touch) begin
            // a touch in the poll cycle also blocks the next poll
            reg_touch_r <= 1'b1;
        end else if (sample_phase) begin
            reg_touch_r <= 1'b0;
        end
    end

    // gate by individual and global enables
    assign pend = samp_r & enab & {15{interrupt_enable_low_group_r[`TLV_EA_BIT]}};
    assign pend_hi = pend & prio;
    assign pend_lo = pend & ~prio;

    // fixed polling order, first in list wins
    always_comb begin
        win_hi = TLV_X0;
        win_lo = TLV_X0;
        for (int i = 14; i >= 0; i--) begin
            if (pend_hi[POLL_ORDER[i]]) begin
                win_hi = POLL_ORDER[i];
            end
            if (pend_lo[POLL_ORDER[i]]) begin
                win_lo = POLL_ORDER[i];
            end
        end
    end

    // suppress midway, after blocking instr, or when busy
    assign blocked = !last_cycle || block_instr || reg_touch ||
        reg_touch_r || return_from_interrupt_exec;
    // high level first, high never preempted
    assign take_hi = (|pend_hi) && !lvl_hi_r;
    assign take_lo = (|pend_lo) && !lvl_hi_r && !lvl_lo_r;
    // decided only from this poll, nothing held over
    assign grant = sample_phase && !blocked && (take_hi || take_lo);
    assign win = take_hi ? win_hi : win_lo;

    // forced call: push PC, load vector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            call_req_r <= 1'b0;
            call_hi_r <= 1'b0;
            call_src_r <= TLV_X0;
            call_vector_r <= `TLV_VEC_BASE;
        end else begin
            call_req_r <= grant;
            if (grant) begin
                call_hi_r <= take_hi;
                call_src_r <= win;
                // base plus eight per vector step
                call_vector_r <= 16'(`TLV_VEC_BASE +
                    16'(win) * `TLV_VEC_STEP);
            end
        end
    end

    // return pops the two saved PC bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pop_pc_r <= 1'b0;
        end else begin
            pop_pc_r <= return_from_interrupt_exec;
        end
    end

    // level flops: set on accept, cleared by return
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_hi_r <= 1'b0;
            lvl_lo_r <= 1'b0;
        end else if (grant) begin
            if (take_hi) begin
                lvl_hi_r <= 1'b1;
            end else begin
                lvl_lo_r <= 1'b1;
            end
        end else if (return_from_interrupt_exec) begin
            if (lvl_hi_r) begin
                lvl_hi_r <= 1'b0;
            end else begin
                lvl_lo_r <= 1'b0;
            end
        end
    end

    // hardware clears only timer 0/1 and edge-mode external flags;
    // all others stay for software to clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_t0_r <= 1'b0;
            clr_t1_r <= 1'b0;
            clr_xa_r <= 1'b0;
            clr_xb_r <= 1'b0;
        end else begin
            clr_t0_r <= grant && win == TLV_T0;
            clr_t1_r <= grant && win == TLV_T1;
            clr_xa_r <= grant && win == TLV_X0 && ext0_edge_mode;
            clr_xb_r <= grant && win == TLV_X1SEC && ext1_edge_mode;
        end
    end

    assign reg_rdata = rdata_r;
    assign call_req = call_req_r;
    assign push_pc = call_req_r;
    assign call_vector = call_vector_r;
    assign pop_pc = pop_pc_r;
    assign level_active_hi = lvl_hi_r;
    assign level_active_lo = lvl_lo_r;
    assign clr_timer0_flag = clr_t0_r;
    assign clr_timer1_flag = clr_t1_r;
    assign clr_ext_flag_a = clr_xa_r;
    assign clr_ext_flag_b = clr_xb_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_call_on_poll: assert property (
        call_req_r |-> $past(sample_phase) && $past(last_cycle))
        else $error("call without poll in final cycle");

    chk_call_needs_flag: assert property (
        call_req_r |-> $past(|(samp_r & (15'h1 << win))))
        else $error("call for a source not sampled set");

    chk_vector_value: assert property (
        call_req_r |-> call_vector_r[2:0] == 3'h3 &&
            call_vector_r <= `TLV_VEC_LAST &&
            call_vector_r[6:3] == 4'(call_src_r))
        else $error("vector does not match source");

    chk_timer_clear: assert property (
        call_req_r && (call_src_r == TLV_T0) |-> clr_t0_r && !clr_t1_r)
        else $error("timer 0 flag not cleared on vectoring");

    chk_ext_level_kept: assert property (
        clr_xa_r |-> call_req_r && call_src_r == TLV_X0 &&
            $past(ext0_edge_mode))
        else $error("external flag cleared in level mode");

    chk_level_set: assert property (
        call_req_r |-> (call_hi_r ? lvl_hi_r : lvl_lo_r))
        else $error("level flop not set on accept");

    chk_global_gate: assert property (
        call_req_r |-> $past(interrupt_enable_low_group_r[`TLV_EA_BIT]))
        else $error("call while global enable clear");

    chk_hi_not_preempt: assert property (
        $past(lvl_hi_r) |-> !call_req_r)
        else $error("high level routine preempted");

    chk_return_from_interrupt_pop: assert property (
        return_from_interrupt_exec |=> pop_pc_r ##1 !pop_pc_r || $past(return_from_interrupt_exec))
        else $error("return did not pop program counter");

    chk_block_instr: assert property (
        call_req_r |-> !$past(block_instr) && !$past(return_from_interrupt_exec))
        else $error("call after blocking instruction");

    chk_hi_first: assert property (
        call_req_r && $past(|pend_hi) |-> call_hi_r)
        else $error("low level served before high");

    chk_enable_bit: assert property (
        call_req_r |-> $past(|(enab & (15'h1 << win))))
        else $error("call for disabled source");
endmodule
`default_nettype wire

// ===== verif/tlv_seq_model.sv
// model of the instruction sequencer beside the interrupt unit
// assumes a four-clock machine cycle; the bench steers it by levels
`timescale 1ns/1ps
`default_nettype none
module tlv_seq_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench controls
    input wire logic mid,
    input wire logic blk,
    input wire logic ret_go,
    // sequencer side
    output logic sample_phase,
    output logic last_cycle,
    output logic block_instr,
    output logic return_from_interrupt_exec
);
    logic [1:0] phase_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= 2'h0;
            sample_phase <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            sample_phase <= (phase_r == 2'h3);
        end
    end
    // mid holds the instruction short of its final cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_cycle <= 1'b0;
            block_instr <= 1'b0;
            return_from_interrupt_exec <= 1'b0;
        end else begin
            last_cycle <= !mid;
            block_instr <= blk;
            return_from_interrupt_exec <= ret_go;
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_tlv_intc.sv
// bench for the interrupt vectoring unit
// assumes the sequencer model and a 40 ns clock
`timescale 1ns/1ps
`default_nettype none
module test_tlv_intc;
import tlv_pkg::*;
logic clk;
logic rst = 1;
logic [7:0] reg_addr = 0;
tlv_byte_t reg_wdata = 0;
tlv_byte_t reg_rdata;
logic reg_wr = 0, reg_rd = 0, ext_request_flag_a = 0;
logic ext_request_flag_b = 0, ext0_edge_mode = 1, ext1_edge_mode = 0;
logic seconds_flag = 0, timer0_ovf_flag = 0, timer1_ovf_flag = 0;
logic uart_flag = 0, i2c_flag = 0, adc_flag = 0, timer2_ovf_flag = 0;
logic [3:0] capture_flags = 0;
logic [2:0] compare_flags = 0;
logic clr_timer0_flag, clr_timer1_flag, clr_ext_flag_a, clr_ext_flag_b;
logic sample_phase, last_cycle, block_instr, return_from_interrupt_exec, call_req;
logic push_pc, pop_pc, level_active_hi, level_active_lo;
logic mid = 0, blk = 0, ret_go = 0;
tlv_addr_t call_vector;
int errors = 0;
int checks_done = 0;
tlv_intc i_tlv_intc (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_request_flag_a, .ext_request_flag_b,
    .ext0_edge_mode, .ext1_edge_mode, .seconds_flag, .timer0_ovf_flag,
    .timer1_ovf_flag, .uart_flag, .i2c_flag, .adc_flag, .capture_flags,
    .compare_flags, .timer2_ovf_flag, .clr_timer0_flag, .clr_timer1_flag,
    .clr_ext_flag_a, .clr_ext_flag_b, .sample_phase, .last_cycle,
    .block_instr, .return_from_interrupt_exec, .call_req, .call_vector, .push_pc, .pop_pc,
    .level_active_hi, .level_active_lo);
tlv_seq_model i_tlv_seq_model (.clk, .rst, .mid, .blk, .ret_go,
    .sample_phase, .last_cycle, .block_instr, .return_from_interrupt_exec);
initial begin
    clk = 0;
    forever #20 clk = ~clk;
end
task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    end
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
endtask
task rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk(reg_rdata === d, "read data");
endtask
// index in vector order
task set_flag(input int i, input logic v);
    case (i)
        0: ext_request_flag_a <= v;
        1: timer0_ovf_flag <= v;
        2: seconds_flag <= v;
        3: timer1_ovf_flag <= v;
        4: uart_flag <= v;
        5: i2c_flag <= v;
        6, 7, 8, 9: capture_flags[i-6] <= v;
        10: adc_flag <= v;
        11, 12, 13: compare_flags[i-11] <= v;
        default: timer2_ovf_flag <= v;
    endcase
endtask
task get_call(input int i);
    int n;
    n = 0;
    @(negedge clk);
    while (call_req !== 1'b1 && n < 40) begin
        n++;
        @(negedge clk);
    end
    chk(call_req === 1'b1 && push_pc === 1'b1 &&
        call_vector === 16'(3 + 8 * i), "vector");
    chk(clr_timer0_flag === (i == 1) && clr_timer1_flag === (i == 3) &&
        clr_ext_flag_a === (i == 0 && ext0_edge_mode) &&
        clr_ext_flag_b === (i == 2 && ext1_edge_mode), "clear");
endtask
task no_call(input int n);
    bit s;
    s = 0;
    repeat (n) begin
        @(negedge clk);
        if (call_req !== 1'b0)
            s = 1;
    end
    chk(!s, "call seen");
endtask
// software clears the flag, then returns
task drop_ret(input int i);
    @(posedge clk);
    set_flag(i, 0);
    repeat (10) @(posedge clk);
    ret_go <= 1;
    @(posedge clk);
    ret_go <= 0;
    repeat (2) @(negedge clk);
    chk(pop_pc === 1'b1, "pop");
endtask
task t_regs;
    logic [7:0] a [4];
    a = '{8'ha8, 8'hb8, 8'he8, 8'hf8};
    foreach (a[k]) rd(a[k], 8'h00);
    foreach (a[k]) begin
        wr(a[k], 8'hff);
        rd(a[k], k == 1 ? 8'h7f : 8'hff);
    end
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00);
    wr(8'hb8, 8'h00);
    wr(8'hf8, 8'h00);
    $display("register test done");
endtask
task t_vec;
    for (int i = 0; i < 15; i++) begin
        @(posedge clk);
        set_flag(i, 1);
        get_call(i);
        chk(level_active_lo === 1'b1, "level set");
        drop_ret(i);
        chk(level_active_lo === 1'b0, "level clear");
    end
    $display("vector test done");
endtask
task t_poll;
    int po [15];
    po = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
    @(posedge clk);
    for (int i = 0; i < 15; i++) set_flag(i, 1);
    foreach (po[k]) begin
        get_call(po[k]);
        drop_ret(po[k]);
    end
    $display("poll order test done");
endtask
task t_pre;
    wr(8'hb8, 8'h08);
    @(posedge clk);
    set_flag(0, 1);
    set_flag(3, 1);
    get_call(3);
    chk(level_active_hi === 1'b1, "high level");
    no_call(16);
    drop_ret(3);
    get_call(0);
    @(posedge clk);
    set_flag(3, 1);
    get_call(3);
    chk(level_active_hi === 1 && level_active_lo === 1, "nest");
    drop_ret(3);
    chk(level_active_hi === 0 && level_active_lo === 1, "unnest");
    drop_ret(0);
    wr(8'hb8, 8'h00);
    $display("preempt test done");
endtask
task t_gate;
    wr(8'ha8, 8'h7f);
    @(posedge clk);
    set_flag(1, 1);
    no_call(16);
    wr(8'ha8, 8'h80);
    no_call(16);
    @(posedge clk);
    blk <= 1;
    wr(8'ha8, 8'h82);
    no_call(16);
    @(posedge clk);
    blk <= 0;
    get_call(1);
    drop_ret(1);
    @(posedge clk);
    mid <= 1;
    set_flag(1, 1);
    no_call(16);
    @(posedge clk);
    set_flag(1, 0);
    repeat (10) @(posedge clk);
    mid <= 0;
    no_call(16);
    $display("gating test done");
endtask
// level-mode external 0 keeps its flag, edge-mode external 1 is cleared
task t_ext;
    wr(8'ha8, 8'h85);
    @(posedge clk);
    ext0_edge_mode <= 0;
    ext1_edge_mode <= 1;
    ext_request_flag_a <= 1;
    get_call(0);
    drop_ret(0);
    @(posedge clk);
    ext_request_flag_b <= 1;
    get_call(2);
    @(posedge clk);
    ext_request_flag_b <= 0;
    drop_ret(2);
    $display("external mode test done");
endtask
initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude;
end
initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_vec;
    t_poll;
    t_pre;
    t_gate;
    t_ext;
    conclude;
end
endmodule
`default_nettype wire
